// *** sim/ssm_partner.sv ***
`timescale 1ns/1ns
module ssm_partner
(
   input  wire logic       clk,
   input  wire logic       ck,
   input  wire logic       dt,
   input  wire logic       own,
   input  wire logic       listen,
   input  wire logic       talk,
   input  wire logic [3:0] nbits,
   input  wire logic [8:0] tw,
   output logic            ck_out,
   output logic            dt_out
);
   logic [8:0] sh;
   logic [3:0] bc;
   logic [3:0] idx;
   logic       junk;
   logic [8:0] rxq[$];

   initial
   begin
      ck_out = 1'b0;
      junk   = 1'b0;
      sh     = 9'h000;
      bc     = 4'h0;
      idx    = 4'h0;
   end
   // ----------------------------------------------------------------
   // capture: mid-bit when clocked by the port, on the fall when we clock
   // ----------------------------------------------------------------
   task automatic take();
      sh = {dt, sh[8:1]};
      bc = bc + 4'h1;
      if (bc == nbits)
      begin
         rxq.push_back(sh >> (4'h9 - nbits));
         bc = 4'h0;
      end
   endtask
   always @(posedge ck) if (listen && !own) take();
   always @(negedge ck) if (listen && own) take();
   always @(negedge listen) bc = 4'h0;
   // ----------------------------------------------------------------
   // send: next bit after each falling edge, lsb first
   // ----------------------------------------------------------------
   always @(negedge ck or negedge talk)
      if (!talk) idx = 4'h0;
      else idx = (idx + 4'h1 == nbits) ? 4'h0 : idx + 4'h1;
   // a released line never keeps the last level
   always @(posedge clk) junk <= ~junk;
   assign dt_out = talk ? tw[idx] : junk;
   // clock stands low between frames; 32 ns period
   task automatic frame(input int n);
      repeat (n)
      begin
         #16 ck_out = 1'b1;
         #16 ck_out = 1'b0;
      end
   endtask
endmodule // ssm_partner

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_top;
   import ssm_pkg::*;
   logic       clk, rst, low_power, own, listen, talk;
   logic       d_ck, d_ck_oe_n, d_dt, d_dt_oe_n, tx_irq, rx_irq, wake, p_ck, p_dt;
   ssm_bus_t   bus;
   logic [7:0] rdata;
   logic [3:0] nbits;
   logic [8:0] tw;
   logic [8:0] w;
   wire        ck_line = d_ck_oe_n ? p_ck : d_ck;
   wire        dt_line = d_dt_oe_n ? p_dt : d_dt;
   int         error_cnt, checked, i;

   ssm_sync_serial u_ssm_sync_serial (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .low_power(low_power), .shift_clock_pin_in(ck_line), .shift_clock_pin_out(d_ck),
      .shift_clock_pin_oe_n(d_ck_oe_n), .shift_data_pin_in(dt_line),
      .shift_data_pin_out(d_dt), .shift_data_pin_oe_n(d_dt_oe_n), .tx_irq(tx_irq),
      .rx_irq(rx_irq), .wake(wake));
   ssm_partner u_ssm_partner (.clk(clk), .ck(ck_line), .dt(dt_line), .own(own),
      .listen(listen), .talk(talk), .nbits(nbits), .tw(tw), .ck_out(p_ck), .dt_out(p_dt));
   // ----------------------------------------------------------------
   // register port access
   // ----------------------------------------------------------------
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
   endtask
   task rchk(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1;
      `CHK(n, e, rdata)
   endtask
   task wait_rx(input int n);
      for (i = 0; i < 3000 && u_ssm_partner.rxq.size() < n; i++) @(posedge clk);
      `CHK("word count", 1'b1, u_ssm_partner.rxq.size() >= n)
   endtask
   task wchk(input logic [8:0] e);
      w = u_ssm_partner.rxq.pop_front();
      `CHK("word", e, w)
   endtask
   task summarize;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, reset, watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      #200000;
      error_cnt++;
      summarize;
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      rst = 1'b1; low_power = 1'b0; own = 1'b0; listen = 1'b1; talk = 1'b0;
      nbits = 4'h8; tw = 9'h000; bus = '0; error_cnt = 0; checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rchk(REG_FLAGS, 8'h10, "flags");
      rchk(REG_TX_STATUS, 8'h02, "tx status");
      rchk(4'ha, 8'h00, "unmapped");
      wr(REG_FLAGS, 8'h00);
      rchk(REG_FLAGS, 8'h10, "flags");
      wr(REG_DIV_HIGH, 8'h5a);
      rchk(REG_DIV_HIGH, 8'h5a, "div high");
      wr(REG_DIV_HIGH, 8'h00);
      // master transmit, two words back to back
      wr(REG_DIV_LOW, 8'h03);
      wr(REG_RX_STATUS, 8'h80);
      wr(REG_TX_STATUS, 8'hb0);
      wr(REG_TX_BUFFER, 8'ha5);
      rchk(REG_FLAGS, 8'h10, "flags");
      wr(REG_TX_BUFFER, 8'h3c);
      rchk(REG_FLAGS, 8'h00, "flags");
      rchk(REG_TX_STATUS, 8'hb0, "tx status");
      wait_rx(2);
      wchk(9'h0a5);
      wchk(9'h03c);
      // the last falling edge comes half a shift clock after the last capture
      repeat (8) @(posedge clk);
      rchk(REG_TX_STATUS, 8'hb2, "tx status");
      rchk(REG_FLAGS, 8'h10, "flags");
      // nine-bit word
      nbits <= 4'h9;
      wr(REG_TX_STATUS, 8'hf1);
      wr(REG_TX_BUFFER, 8'h5a);
      wait_rx(1);
      wchk(9'h15a);
      repeat (8) @(posedge clk);
      nbits <= 4'h8;
      // polarity changes below make edges that are not data
      listen <= 1'b0;
      wr(REG_TX_STATUS, 8'hb0);
      // idle level of the master clock
      #1;
      `CHK("clock idle", 1'b0, d_ck)
      wr(REG_BAUD_CTRL, 8'h10);
      repeat (4) @(posedge clk);
      #1;
      `CHK("clock idle", 1'b1, d_ck)
      `CHK("clock drive", 1'b0, d_ck_oe_n)
      wr(REG_BAUD_CTRL, 8'h00);
      // slave transmit across sleep
      own <= 1'b1;
      wr(REG_ENABLES, 8'h10);
      wr(REG_TX_STATUS, 8'h30);
      repeat (8) @(posedge clk);
      #1;
      `CHK("clock drive", 1'b1, d_ck_oe_n)
      `CHK("data drive", 1'b1, d_dt_oe_n)
      `CHK("tx irq", 1'b1, tx_irq)
      listen <= 1'b1;
      wr(REG_TX_BUFFER, 8'h11);
      wr(REG_TX_BUFFER, 8'h22);
      low_power <= 1'b1;
      rchk(REG_FLAGS, 8'h00, "flags");
      `CHK("wake", 1'b0, wake)
      `CHK("tx irq", 1'b0, tx_irq)
      u_ssm_partner.frame(8);
      repeat (10) @(posedge clk);
      #1;
      `CHK("wake", 1'b1, wake)
      rchk(REG_FLAGS, 8'h10, "flags");
      u_ssm_partner.frame(8);
      wait_rx(2);
      wchk(9'h011);
      wchk(9'h022);
      low_power <= 1'b0;
      own <= 1'b0;
      // master single receive
      wr(REG_TX_STATUS, 8'h90);
      wr(REG_ENABLES, 8'h20);
      listen <= 1'b0;
      talk <= 1'b1;
      tw <= 9'h096;
      wr(REG_RX_STATUS, 8'ha0);
      for (i = 0; i < 500 && rx_irq !== 1'b1; i++) @(posedge clk);
      `CHK("rx irq", 1'b1, rx_irq)
      rchk(REG_RX_STATUS, 8'h80, "rx status");
      rchk(REG_RX_BUFFER, 8'h96, "rx buffer");
      repeat (2) @(posedge clk);
      #1;
      `CHK("rx irq", 1'b0, rx_irq)
      // continuous receive into overrun, then clear
      wr(REG_RX_STATUS, 8'h90);
      repeat (300) @(posedge clk);
      rchk(REG_RX_STATUS, 8'h92, "rx status");
      rchk(REG_RX_BUFFER, 8'h96, "rx buffer");
      wr(REG_RX_STATUS, 8'h80);
      rchk(REG_RX_STATUS, 8'h80, "rx status");
      summarize;
   end
endmodule // tb_top

// *** src/ssm_pkg.sv ***
package ssm_pkg;
   // ----------------------------------------------------------------
   // register indices on the plain port
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 4;
   localparam logic [3:0]  REG_FLAGS      = 4'h0;
   localparam logic [3:0]  REG_ENABLES    = 4'h1;
   localparam logic [3:0]  REG_PRIORITY   = 4'h2;
   localparam logic [3:0]  REG_RX_STATUS  = 4'h3;
   localparam logic [3:0]  REG_TX_BUFFER  = 4'h4;
   localparam logic [3:0]  REG_TX_STATUS  = 4'h5;
   localparam logic [3:0]  REG_BAUD_CTRL  = 4'h6;
   localparam logic [3:0]  REG_DIV_HIGH   = 4'h7;
   localparam logic [3:0]  REG_DIV_LOW    = 4'h8;
   localparam logic [3:0]  REG_RX_BUFFER  = 4'h9;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int B_RX_FLAG      = 5;   // flags / enables
   localparam int B_TX_FLAG      = 4;
   localparam int B_PORT_EN      = 7;   // rx status/control
   localparam int B_RX9_EN       = 6;
   localparam int B_SINGLE_RX    = 5;
   localparam int B_CONT_RX      = 4;
   localparam int B_ADDR_DET     = 3;
   localparam int B_FRAME_ERR    = 2;
   localparam int B_OVERRUN      = 1;
   localparam int B_RX9_BIT      = 0;
   localparam int B_CLK_MASTER   = 7;   // tx status/control
   localparam int B_TX9_EN       = 6;
   localparam int B_TX_EN        = 5;
   localparam int B_SYNC_MODE    = 4;
   localparam int B_SEND_BRK     = 3;
   localparam int B_HIGH_RATE    = 2;
   localparam int B_SHIFT_EMPTY  = 1;
   localparam int B_TX9_BIT      = 0;
   localparam int B_CLK_POL      = 4;   // baud control
   localparam int B_DIV_WIDE     = 3;
   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_RESET      = 8'h00;
   localparam logic [15:0] CNT_ZERO       = 16'h0000;
   localparam logic [3:0]  BITS_EIGHT     = 4'h8;
   localparam logic [3:0]  BITS_NINE      = 4'h9;
   localparam logic [3:0]  BIT_ZERO       = 4'h0;
   localparam logic [3:0]  BIT_ONE        = 4'h1;
   localparam logic [15:0] CNT_ONE        = 16'h0001;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ssm_bus_t;

   typedef struct packed {
      logic dout;
      logic oe_n;
   } ssm_pin_t;
endpackage

// *** src/ssm_sync_serial.sv ***
`timescale 1ns/1ns
// Summary of operation
// - shift register reloads from buffer only after the last bit of the prior word
// - buffer-to-shift move takes one cycle and then sets the buffer-empty flag
// - buffer-empty flag ignores its enable, software cannot clear it, a write does
// - read-only shift-empty bit shows the shift register idle, no interrupt
// - with nine-bit mode the stored ninth bit goes out as bit nine
// - single or continuous receive enable starts a synchronous reception
// - master reception samples the data line on the falling shift clock edge
// - single receive takes one word, continuous runs on and wins if both set
// - a finished word sets the receive flag, interrupt when enabled
// - status shows ninth bit and errors, receive buffer shows eight data bits
// - clearing continuous receive clears a pending receive error
// - clearing the clock source bit selects slave, clock taken from the pin
// - slave mode shifts on the external clock even in low-power mode
// - two writes then sleep: first word sent, second kept, flag stays clear
// - after the first word the second moves in and the flag then sets
// - with transmit interrupt enabled a set empty flag wakes from sleep
// - half duplex: no reception while transmitting and no transmit while receiving
// - clock idle polarity bit sets the shift clock idle level
// - port enable turns the two pins into shift clock and shift data
module ssm_sync_serial
   import ssm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire ssm_bus_t   bus,
   output logic [7:0]      rdata,
   input  wire logic       low_power,
   input  wire logic       shift_clock_pin_in,
   output logic            shift_clock_pin_out,
   output logic            shift_clock_pin_oe_n,
   input  wire logic       shift_data_pin_in,
   output logic            shift_data_pin_out,
   output logic            shift_data_pin_oe_n,
   output logic            tx_irq,
   output logic            rx_irq,
   output logic            wake
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  flags_en, next_flags_en, prio, next_prio;
   logic [7:0]  rx_ctl, next_rx_ctl, tx_ctl, next_tx_ctl;
   logic [7:0]  baud_ctl, next_baud_ctl, div_hi, next_div_hi, div_lo, next_div_lo;
   logic [7:0]  tx_buffer, next_tx_buffer, rx_buffer, next_rx_buffer;
   logic        buf_full, next_buf_full, rx_flag, next_rx_flag;
   logic        overrun, next_overrun, rx_ninth, next_rx_ninth;
   logic [7:0]  next_rdata;
   logic [8:0]  tx_shift_reg, next_tx_shift_reg, rx_shift, next_rx_shift;
   logic [3:0]  tx_bits, next_tx_bits, rx_bits, next_rx_bits;
   logic        tx_busy, next_tx_busy, rx_active, next_rx_active;
   logic [15:0] baud_cnt, next_baud_cnt;
   logic        sclk, next_sclk;
   logic        ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
   ssm_pin_t    ck_pin, next_ck_pin, dt_pin, next_dt_pin;
   logic        next_tx_irq, next_rx_irq, next_wake;

   // ----------------------------------------------------------------
   // decoded controls
   // ----------------------------------------------------------------
   logic        mode_ok, master, tx_load, fall, clk_run, toggle, rx_done;
   logic        single_rx, cont_rx;
   logic [3:0]  tx_nbits, rx_nbits;
   logic [15:0] divisor;

   assign mode_ok   = rx_ctl[B_PORT_EN] & tx_ctl[B_SYNC_MODE];
   assign master    = mode_ok & tx_ctl[B_CLK_MASTER];
   assign single_rx = rx_ctl[B_SINGLE_RX];
   assign cont_rx   = rx_ctl[B_CONT_RX];
   assign tx_nbits  = tx_ctl[B_TX9_EN] ? BITS_NINE : BITS_EIGHT;
   assign rx_nbits  = rx_ctl[B_RX9_EN] ? BITS_NINE : BITS_EIGHT;
   assign divisor   = baud_ctl[B_DIV_WIDE] ? {div_hi, div_lo} : {8'h00, div_lo};
   // load only when the previous word has fully left and no reception runs
   assign tx_load   = mode_ok & tx_ctl[B_TX_EN] & buf_full & !tx_busy
                      & !rx_active;
   // master clock runs while a word shifts or until it reaches its idle level; sleep stops it
   assign clk_run   = master & !low_power & (tx_busy | rx_active
                      | (sclk != baud_ctl[B_CLK_POL]));
   assign toggle    = clk_run & (baud_cnt == divisor);
   // falling shift clock edge: own clock in master, pin in slave
   assign fall      = master ? (toggle & sclk)
                             : (mode_ok & ck_s3 & !ck_s2);
   assign rx_done   = rx_active & fall & (rx_bits == rx_nbits - BIT_ONE);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_s3 <= 1'b0;
         dt_s1 <= 1'b0;
         dt_s2 <= 1'b0;
      end
      else
      begin
         ck_s1 <= shift_clock_pin_in;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
         dt_s1 <= shift_data_pin_in;
         dt_s2 <= dt_s1;
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   always_comb
   begin
      next_flags_en  = flags_en;
      next_prio      = prio;
      next_rx_ctl    = rx_ctl;
      next_tx_ctl    = tx_ctl;
      next_baud_ctl  = baud_ctl;
      next_div_hi    = div_hi;
      next_div_lo    = div_lo;
      next_tx_buffer = tx_buffer;
      next_rx_buffer = rx_buffer;
      next_buf_full  = buf_full;
      next_rx_flag   = rx_flag;
      next_overrun   = overrun;
      next_rx_ninth  = rx_ninth;
      next_rdata     = REG_RESET;
      if (tx_load)
         next_buf_full = 1'b0;
      if (bus.rd && bus.addr == REG_RX_BUFFER)
         next_rx_flag = 1'b0;
      if (bus.wr)
      begin
         unique case (bus.addr)
            REG_ENABLES:   next_flags_en = bus.wdata;
            REG_PRIORITY:  next_prio = bus.wdata;
            REG_RX_STATUS: next_rx_ctl = bus.wdata & 8'hf8;
            REG_TX_STATUS: next_tx_ctl = bus.wdata & 8'hfd;
            REG_BAUD_CTRL: next_baud_ctl = bus.wdata & 8'h18;
            REG_DIV_HIGH:  next_div_hi = bus.wdata;
            REG_DIV_LOW:   next_div_lo = bus.wdata;
            REG_TX_BUFFER:
            begin
               next_tx_buffer = bus.wdata;
               next_buf_full  = 1'b1;
            end
            default: ;
         endcase
      end
      if (!next_rx_ctl[B_CONT_RX])
         next_overrun = 1'b0;
      if (rx_done)
      begin
         if (rx_flag && !next_rx_flag)
            next_rx_flag = 1'b1;
         if (rx_flag)
            next_overrun = next_rx_ctl[B_CONT_RX] | overrun;
         else
         begin
            next_rx_buffer = rx_nbits == BITS_NINE ? rx_shift[8:1] : rx_shift[8:1];
            next_rx_ninth  = dt_s2;
            if (rx_nbits == BITS_EIGHT)
               next_rx_buffer = {dt_s2, rx_shift[8:2]};
            else
               next_rx_buffer = rx_shift[8:1];
            if (rx_nbits == BITS_EIGHT)
               next_rx_ninth = 1'b0;
            next_rx_flag = 1'b1;
         end
         if (!cont_rx)
            next_rx_ctl[B_SINGLE_RX] = 1'b0;
      end
      if (bus.rd)
      begin
         unique case (bus.addr)
            REG_FLAGS:     next_rdata = {2'b00, rx_flag, !buf_full, 4'h0};
            REG_ENABLES:   next_rdata = flags_en;
            REG_PRIORITY:  next_rdata = prio;
            REG_RX_STATUS: next_rdata = {rx_ctl[7:3], 1'b0, overrun, rx_ninth};
            REG_TX_BUFFER: next_rdata = tx_buffer;
            REG_TX_STATUS: next_rdata = {tx_ctl[7:2], !tx_busy, tx_ctl[0]};
            REG_BAUD_CTRL: next_rdata = baud_ctl;
            REG_DIV_HIGH:  next_rdata = div_hi;
            REG_DIV_LOW:   next_rdata = div_lo;
            REG_RX_BUFFER: next_rdata = rx_buffer;
            default:       next_rdata = REG_RESET;
         endcase
      end
      next_tx_irq = !next_buf_full & flags_en[B_TX_FLAG];
      next_rx_irq = next_rx_flag & flags_en[B_RX_FLAG];
      next_wake   = low_power & (next_tx_irq | next_rx_irq);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         flags_en  <= REG_RESET;
         prio      <= REG_RESET;
         rx_ctl    <= REG_RESET;
         tx_ctl    <= REG_RESET;
         baud_ctl  <= REG_RESET;
         div_hi    <= REG_RESET;
         div_lo    <= REG_RESET;
         tx_buffer <= REG_RESET;
         rx_buffer <= REG_RESET;
         buf_full  <= 1'b0;
         rx_flag   <= 1'b0;
         overrun   <= 1'b0;
         rx_ninth  <= 1'b0;
         rdata     <= REG_RESET;
         tx_irq    <= 1'b0;
         rx_irq    <= 1'b0;
         wake      <= 1'b0;
      end
      else
      begin
         flags_en  <= next_flags_en;
         prio      <= next_prio;
         rx_ctl    <= next_rx_ctl;
         tx_ctl    <= next_tx_ctl;
         baud_ctl  <= next_baud_ctl;
         div_hi    <= next_div_hi;
         div_lo    <= next_div_lo;
         tx_buffer <= next_tx_buffer;
         rx_buffer <= next_rx_buffer;
         buf_full  <= next_buf_full;
         rx_flag   <= next_rx_flag;
         overrun   <= next_overrun;
         rx_ninth  <= next_rx_ninth;
         rdata     <= next_rdata;
         tx_irq    <= next_tx_irq;
         rx_irq    <= next_rx_irq;
         wake      <= next_wake;
      end
   end

   // ----------------------------------------------------------------
   // shift engine and pins
   // ----------------------------------------------------------------
   always_comb
   begin
      next_baud_cnt     = clk_run ? baud_cnt + CNT_ONE : CNT_ZERO;
      next_sclk         = sclk;
      next_tx_shift_reg = tx_shift_reg;
      next_tx_bits      = tx_bits;
      next_tx_busy      = tx_busy;
      next_rx_shift     = rx_shift;
      next_rx_bits      = rx_bits;
      next_rx_active    = rx_active;
      if (toggle)
      begin
         next_baud_cnt = CNT_ZERO;
         next_sclk     = !sclk;
      end
      if (!master)
         next_sclk = baud_ctl[B_CLK_POL];
      if (tx_load)
      begin
         next_tx_shift_reg = {tx_ctl[B_TX9_BIT], tx_buffer};
         next_tx_bits      = BIT_ZERO;
         next_tx_busy      = 1'b1;
      end
      else if (tx_busy && fall)
      begin
         next_tx_shift_reg = {1'b0, tx_shift_reg[8:1]};
         next_tx_bits      = tx_bits + BIT_ONE;
         if (tx_bits == tx_nbits - BIT_ONE)
            next_tx_busy = 1'b0;
      end
      if (!mode_ok || !tx_ctl[B_TX_EN])
         next_tx_busy = 1'b0;
      if (!rx_active)
         next_rx_bits = BIT_ZERO;
      else if (fall)
      begin
         next_rx_shift = {dt_s2, rx_shift[8:1]};
         next_rx_bits  = rx_done ? BIT_ZERO : rx_bits + BIT_ONE;
      end
      // start and stop as soon as the enables change, even mid-word; a single word ends itself
      next_rx_active = mode_ok & !next_tx_busy & !tx_load
                       & (cont_rx | single_rx) & !overrun
                       & !(rx_done & !cont_rx);
      next_ck_pin.dout = next_sclk;
      next_ck_pin.oe_n = !master;
      next_dt_pin.dout = next_tx_shift_reg[0];
      next_dt_pin.oe_n = !(mode_ok & next_tx_busy);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         baud_cnt     <= CNT_ZERO;
         sclk         <= 1'b0;
         tx_shift_reg <= 9'h000;
         tx_bits      <= BIT_ZERO;
         tx_busy      <= 1'b0;
         rx_shift     <= 9'h000;
         rx_bits      <= BIT_ZERO;
         rx_active    <= 1'b0;
         ck_pin       <= 2'b01;
         dt_pin       <= 2'b01;
      end
      else
      begin
         baud_cnt     <= next_baud_cnt;
         sclk         <= next_sclk;
         tx_shift_reg <= next_tx_shift_reg;
         tx_bits      <= next_tx_bits;
         tx_busy      <= next_tx_busy;
         rx_shift     <= next_rx_shift;
         rx_bits      <= next_rx_bits;
         rx_active    <= next_rx_active;
         ck_pin       <= next_ck_pin;
         dt_pin       <= next_dt_pin;
      end
   end

   assign shift_clock_pin_out  = ck_pin.dout;
   assign shift_clock_pin_oe_n = ck_pin.oe_n;
   assign shift_data_pin_out   = dt_pin.dout;
   assign shift_data_pin_oe_n  = dt_pin.oe_n;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   load_sets_flag_a: assert property (
      tx_load && !(bus.wr && bus.addr == REG_TX_BUFFER) |=> !buf_full ##0 tx_busy)
      else $error("buffer empty flag not set after load");
   busy_holds_a: assert property (
      tx_busy && !fall && mode_ok && tx_ctl[B_TX_EN] |=> tx_busy && $stable(tx_shift_reg))
      else $error("shift register changed before last bit");
   write_clears_a: assert property (
      bus.wr && bus.addr == REG_TX_BUFFER |=> buf_full)
      else $error("buffer write did not clear empty flag");
   shift_empty_read_a: assert property (
      bus.rd && bus.addr == REG_TX_STATUS |=> rdata[B_SHIFT_EMPTY] == !$past(tx_busy))
      else $error("shift empty bit wrong");
   rx_done_flag_a: assert property (
      rx_done && !rx_flag |=> rx_flag && rx_irq == $past(flags_en[B_RX_FLAG]))
      else $error("receive flag or request missing");
   half_duplex_a: assert property (
      !(tx_busy && rx_active))
      else $error("transmit and receive overlap");
   clock_idle_a: assert property (
      (master && !clk_run)[*3] |-> shift_clock_pin_out == baud_ctl[B_CLK_POL])
      else $error("shift clock not at idle level");
   single_word_a: assert property (
      rx_done && single_rx && !cont_rx |=> !single_rx && !rx_active)
      else $error("single receive did not stop");
   error_clear_a: assert property (
      !cont_rx |=> !overrun)
      else $error("overrun not cleared");
   slave_clock_a: assert property (
      mode_ok && !tx_ctl[B_CLK_MASTER] |=> shift_clock_pin_oe_n)
      else $error("slave drives the clock pin");
endmodule // ssm_sync_serial
